/* tb_wor_option_bank.sv */
// self-checking bench for the write-once option register bank
`timescale 1ns/1ps
module tb_wor_option_bank;
	typedef struct {
		logic [31:0] a;
		logic [7:0] d;
		logic [31:0] q;
		logic [1:0] r;
	} wor_row_t;
	logic core_clk, resetn, porn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic watchdogDisable, stopEnable, serialPortClockSource, oscPinOneIsClock;
	logic oscPinTwoIsCrystal, externalOscEnable, monitorCrystalRange;
	logic slowCrystalSelect, oscillatorOnInStop, voltageMonitorMode;
	logic [12:0] stopRecoveryCycles, stabilizationCycles;
	logic [17:0] watchdogTimeoutCycles;
	logic [7:0] timebasePrescale;
	int num_errors = 0;
	int tests_run = 0;
	wor_row_t rows [5];
	wor_option_bank u_wor_option_bank (.*);
	function automatic logic [63:0] flags();
		return {54'h0, watchdogDisable, stopEnable, serialPortClockSource,
			oscPinOneIsClock, oscPinTwoIsCrystal, externalOscEnable,
			monitorCrystalRange, slowCrystalSelect, oscillatorOnInStop,
			voltageMonitorMode};
	endfunction : flags
	function automatic logic [63:0] cyc();
		return {12'h000, stopRecoveryCycles, watchdogTimeoutCycles,
			stabilizationCycles, timebasePrescale};
	endfunction : cyc
	task automatic stop_test;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [63:0] e, g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic guard(inout int n);
		n++;
		if (n > 100) begin
			num_errors++;
			stop_test();
		end
	endtask : guard
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			guard(n);
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	// st holds rready low for a while so the slave must keep its answer
	task automatic rdr(input logic [31:0] a, input int st);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (st == 0);
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (n >= st) s_axi_rready <= 1'b1;
			guard(n);
		end while (!(s_axi_rvalid && s_axi_rready));
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rdr
	task automatic rst(input logic p);
		resetn <= 1'b0;
		porn <= p;
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		porn <= 1'b1;
	endtask : rst
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		s_axi_wstrb = 4'hF;
		rows[0] = '{wor_pkg::OPT_TWO_BYTE, 8'h7B, 32'h7B, 2'h0};
		rows[1] = '{wor_pkg::OPT_TWO_BYTE, 8'h00, 32'h7B, 2'h0};
		rows[2] = '{wor_pkg::OPT_ONE_BYTE, 8'h8F, 32'h8F, 2'h0};
		rows[3] = '{wor_pkg::OPT_ONE_BYTE, 8'h00, 32'h8F, 2'h0};
		rows[4] = '{32'h00000074, 8'hFF, 32'h0, 2'h2};
		rst(1'b0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			chk("bresp", 64'(rows[i].r), 64'(rsp));
			rdr(rows[i].a, i);
			chk("rdata", 64'(rows[i].q), 64'(rd));
			chk("rresp", 64'(rows[i].r), 64'(rsp));
		end
		chk("flags", 64'h3FF, flags());
		chk("cyc", 64'({13'h20, 18'h01FF0, 13'h1000, 8'h80}), cyc());
		// plain reset keeps only the voltage mode bit
		rst(1'b1);
		rdr(wor_pkg::OPT_ONE_BYTE, 0);
		chk("keepvm", 64'h08, 64'(rd));
		rdr(wor_pkg::OPT_TWO_BYTE, 0);
		chk("clr", 64'h00, 64'(rd));
		chk("flags0", 64'h001, flags());
		chk("cyc0", 64'({13'h1000, 18'h3FFF0, 13'h10, 8'h01}), cyc());
		// crystal enable alone leaves both pins as io
		wr(wor_pkg::OPT_TWO_BYTE, 8'h20);
		rdr(wor_pkg::OPT_TWO_BYTE, 0);
		chk("xtal", 64'h009, flags());
		chk("cycx", 64'({13'h1000, 18'h3FFF0, 13'h1000, 8'h01}), cyc());
		rst(1'b0);
		rdr(wor_pkg::OPT_ONE_BYTE, 0);
		chk("por", 64'h00, 64'(rd));
		// external clock without crystal: pin one clocks, pin two stays io
		wr(wor_pkg::OPT_TWO_BYTE, 8'h08);
		rdr(wor_pkg::OPT_TWO_BYTE, 0);
		chk("extclk", 64'h050, flags());
		stop_test();
	end
endmodule : tb_wor_option_bank

/* wor_once_reg.sv */
// one write-once option register with its own lock latch
`timescale 1ns/1ps
module wor_once_reg #(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter logic [7:0] POR_ONLY = 8'h00
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic porn,
	input wire logic wrEn,
	input wire logic [7:0] wrData,
	output logic [7:0] value,
	output logic locked
);
	logic [7:0] valQ;
	logic [7:0] valD;
	logic [7:0] porQ;
	logic [7:0] porD;
	logic lockQ;
	logic lockD;

	always_comb begin
		valD = valQ;
		porD = porQ;
		lockD = lockQ;
		if (wrEn && !lockQ) begin
			valD = wrData & ~POR_ONLY;
			porD = wrData & POR_ONLY;
			lockD = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			valQ <= RESET_VAL;
			lockQ <= 1'b0;
		end else begin
			valQ <= valD;
			lockQ <= lockD;
		end
	end

	// power-on-only bits survive ordinary resets
	always_ff @(posedge core_clk or negedge porn) begin
		if (!porn) begin
			porQ <= 8'h00;
		end else begin
			porQ <= porD;
		end
	end

	assign value = valQ | porQ;
	assign locked = lockQ;
endmodule : wor_once_reg

/* wor_option_bank.sv */
// write-once option register bank with AXI4-Lite slave and decoded options
`timescale 1ns/1ps
module wor_option_bank (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic porn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic watchdogDisable,
	output logic stopEnable,
	output logic [12:0] stopRecoveryCycles,
	output logic [17:0] watchdogTimeoutCycles,
	output logic serialPortClockSource,
	output logic oscPinOneIsClock,
	output logic oscPinTwoIsCrystal,
	output logic externalOscEnable,
	output logic monitorCrystalRange,
	output logic [12:0] stabilizationCycles,
	output logic slowCrystalSelect,
	output logic [7:0] timebasePrescale,
	output logic oscillatorOnInStop,
	output logic voltageMonitorMode
);
	logic awHeldQ;
	logic awHeldD;
	logic [31:0] awAddrQ;
	logic [31:0] awAddrD;
	logic wHeldQ;
	logic wHeldD;
	logic [7:0] wDataQ;
	logic [7:0] wDataD;
	logic wLaneQ;
	logic wLaneD;
	logic bValidQ;
	logic bValidD;
	logic [1:0] bRespQ;
	logic [1:0] bRespD;
	logic rValidQ;
	logic rValidD;
	logic [31:0] rDataQ;
	logic [31:0] rDataD;
	logic [1:0] rRespQ;
	logic [1:0] rRespD;
	logic doWrite;
	logic wrOne;
	logic wrTwo;
	logic [7:0] optOne;
	logic [7:0] optTwo;
	logic watchdogDisableD;
	logic stopEnableD;
	logic [12:0] stopRecoveryCyclesD;
	logic [17:0] watchdogTimeoutCyclesD;
	logic serialPortClockSourceD;
	logic oscPinOneIsClockD;
	logic oscPinTwoIsCrystalD;
	logic externalOscEnableD;
	logic monitorCrystalRangeD;
	logic [12:0] stabilizationCyclesD;
	logic slowCrystalSelectD;
	logic [7:0] timebasePrescaleD;
	logic oscillatorOnInStopD;
	logic voltageMonitorModeD;

	// write channel: address and data latched independently, either order
	always_comb begin
		awHeldD = awHeldQ;
		awAddrD = awAddrQ;
		wHeldD = wHeldQ;
		wDataD = wDataQ;
		wLaneD = wLaneQ;
		bValidD = bValidQ;
		bRespD = bRespQ;
		doWrite = 1'b0;
		if (s_axi_awvalid && !awHeldQ && !bValidQ) begin
			awHeldD = 1'b1;
			awAddrD = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHeldQ && !bValidQ) begin
			wHeldD = 1'b1;
			wDataD = s_axi_wdata[7:0];
			wLaneD = s_axi_wstrb[0];
		end
		if (awHeldQ && wHeldQ) begin
			doWrite = wLaneQ;
			awHeldD = 1'b0;
			wHeldD = 1'b0;
			bValidD = 1'b1;
			if (awAddrQ == wor_pkg::OPT_ONE_BYTE ||
					awAddrQ == wor_pkg::OPT_TWO_BYTE) begin
				bRespD = wor_pkg::RESP_OKAY;
			end else begin
				bRespD = wor_pkg::RESP_SLVERR;
			end
		end
		if (bValidQ && s_axi_bready) begin
			bValidD = 1'b0;
		end
	end

	// a refused second write still answers okay; the register just keeps its first value
	assign wrOne = doWrite && awAddrQ == wor_pkg::OPT_ONE_BYTE;
	assign wrTwo = doWrite && awAddrQ == wor_pkg::OPT_TWO_BYTE;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			awHeldQ <= 1'b0;
			awAddrQ <= 32'h00000000;
			wHeldQ <= 1'b0;
			wDataQ <= 8'h00;
			wLaneQ <= 1'b0;
			bValidQ <= 1'b0;
			bRespQ <= 2'h0;
		end else begin
			awHeldQ <= awHeldD;
			awAddrQ <= awAddrD;
			wHeldQ <= wHeldD;
			wDataQ <= wDataD;
			wLaneQ <= wLaneD;
			bValidQ <= bValidD;
			bRespQ <= bRespD;
		end
	end

	wor_once_reg #(
		.RESET_VAL(wor_pkg::OPT_ONE_RESET),
		.POR_ONLY(8'h01 << wor_pkg::VMON_MODE_BIT)
	) uOptOne (
		.core_clk(core_clk),
		.resetn(resetn),
		.porn(porn),
		.wrEn(wrOne),
		.wrData(wDataQ),
		.value(optOne),
		.locked()
	);

	wor_once_reg #(
		.RESET_VAL(wor_pkg::OPT_TWO_RESET),
		.POR_ONLY(8'h00)
	) uOptTwo (
		.core_clk(core_clk),
		.resetn(resetn),
		.porn(porn),
		.wrEn(wrTwo),
		.wrData(wDataQ),
		.value(optTwo),
		.locked()
	);

	// read channel: answer in the same cycle arready rises, one cycle after arvalid is seen
	always_comb begin
		rValidD = rValidQ;
		rDataD = rDataQ;
		rRespD = rRespQ;
		if (rValidQ && s_axi_rready) begin
			rValidD = 1'b0;
		end
		if (s_axi_arvalid && !rValidQ) begin
			rValidD = 1'b1;
			rRespD = wor_pkg::RESP_OKAY;
			if (s_axi_araddr == wor_pkg::OPT_ONE_BYTE) begin
				rDataD = {24'h000000, optOne};
			end else if (s_axi_araddr == wor_pkg::OPT_TWO_BYTE) begin
				rDataD = {24'h000000, optTwo};
			end else begin
				rDataD = 32'h00000000;
				rRespD = wor_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rValidQ <= 1'b0;
			rDataQ <= 32'h00000000;
			rRespQ <= 2'h0;
		end else begin
			rValidQ <= rValidD;
			rDataQ <= rDataD;
			rRespQ <= rRespD;
		end
	end

	assign s_axi_awready = awHeldQ;
	assign s_axi_wready = wHeldQ;
	assign s_axi_bvalid = bValidQ;
	assign s_axi_bresp = bRespQ;
	assign s_axi_arready = rValidQ;
	assign s_axi_rvalid = rValidQ;
	assign s_axi_rdata = rDataQ;
	assign s_axi_rresp = rRespQ;

	// option decode; the flops below only register it, so every output
	// leaves a flip-flop one cycle after the register contents change
	always_comb begin
		watchdogDisableD = optOne[wor_pkg::WDOG_DIS_BIT];
		stopEnableD = optOne[wor_pkg::STOP_EN_BIT];
		stopRecoveryCyclesD = optOne[wor_pkg::SHORT_REC_BIT] ?
			wor_pkg::STOP_REC_SHORT : wor_pkg::STOP_REC_LONG;
		watchdogTimeoutCyclesD = optOne[wor_pkg::WDOG_RATE_BIT] ?
			wor_pkg::WDOG_SHORT : wor_pkg::WDOG_LONG;
		voltageMonitorModeD = optOne[wor_pkg::VMON_MODE_BIT];
		serialPortClockSourceD = optTwo[wor_pkg::SER_SRC_BIT];
		oscPinOneIsClockD = optTwo[wor_pkg::EXT_CLK_BIT];
		oscPinTwoIsCrystalD = optTwo[wor_pkg::EXT_CLK_BIT] &&
			optTwo[wor_pkg::XTAL_EN_BIT];
		externalOscEnableD = optTwo[wor_pkg::EXT_CLK_BIT];
		monitorCrystalRangeD = optTwo[wor_pkg::XTAL_EN_BIT];
		stabilizationCyclesD = optTwo[wor_pkg::XTAL_EN_BIT] ?
			wor_pkg::STAB_XTAL : wor_pkg::STAB_EXT;
		slowCrystalSelectD = optTwo[wor_pkg::SLOW_XTAL_BIT];
		timebasePrescaleD = optTwo[wor_pkg::TB_PRE_BIT] ?
			wor_pkg::TB_PRESCALE : wor_pkg::TB_BYPASS;
		oscillatorOnInStopD = optTwo[wor_pkg::OSC_STOP_BIT];
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			watchdogDisable <= 1'b0;
			stopEnable <= 1'b0;
			stopRecoveryCycles <= wor_pkg::STOP_REC_LONG;
			watchdogTimeoutCycles <= wor_pkg::WDOG_LONG;
			serialPortClockSource <= 1'b0;
			oscPinOneIsClock <= 1'b0;
			oscPinTwoIsCrystal <= 1'b0;
			externalOscEnable <= 1'b0;
			monitorCrystalRange <= 1'b0;
			stabilizationCycles <= wor_pkg::STAB_EXT;
			slowCrystalSelect <= 1'b0;
			timebasePrescale <= wor_pkg::TB_BYPASS;
			oscillatorOnInStop <= 1'b0;
		end else begin
			watchdogDisable <= watchdogDisableD;
			stopEnable <= stopEnableD;
			stopRecoveryCycles <= stopRecoveryCyclesD;
			watchdogTimeoutCycles <= watchdogTimeoutCyclesD;
			serialPortClockSource <= serialPortClockSourceD;
			oscPinOneIsClock <= oscPinOneIsClockD;
			oscPinTwoIsCrystal <= oscPinTwoIsCrystalD;
			externalOscEnable <= externalOscEnableD;
			monitorCrystalRange <= monitorCrystalRangeD;
			stabilizationCycles <= stabilizationCyclesD;
			slowCrystalSelect <= slowCrystalSelectD;
			timebasePrescale <= timebasePrescaleD;
			oscillatorOnInStop <= oscillatorOnInStopD;
		end
	end

	// voltage mode output follows its power-on-only source, so an ordinary
	// reset must not pull it low either
	always_ff @(posedge core_clk or negedge porn) begin
		if (!porn) begin
			voltageMonitorMode <= 1'b0;
		end else begin
			voltageMonitorMode <= voltageMonitorModeD;
		end
	end
endmodule : wor_option_bank

/* wor_option_bank_checker.sv */
// assertion checker for the write-once option register bank
`timescale 1ns/1ps
module wor_option_bank_checker (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic watchdogDisable,
	input wire logic [12:0] stopRecoveryCycles,
	input wire logic [17:0] watchdogTimeoutCycles,
	input wire logic oscPinOneIsClock,
	input wire logic oscPinTwoIsCrystal,
	input wire logic externalOscEnable,
	input wire logic monitorCrystalRange,
	input wire logic [12:0] stabilizationCycles,
	input wire logic [7:0] timebasePrescale
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence s_rdStall;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	property p_rdHold;
		s_rdStall |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rdHold: assert property (p_rdHold) else $error("read data moved");
	property p_recov;
		stopRecoveryCycles inside {13'h0020, 13'h1000};
	endproperty
	a_recov: assert property (p_recov) else $error("bad recovery");
	property p_wdog;
		watchdogTimeoutCycles inside {18'h01FF0, 18'h3FFF0};
	endproperty
	a_wdog: assert property (p_wdog) else $error("bad timeout");
	property p_stab;
		stabilizationCycles == (monitorCrystalRange ? 13'h1000 : 13'h0010);
	endproperty
	a_stab: assert property (p_stab) else $error("bad stab count");
	property p_pinsIo;
		!oscPinOneIsClock |-> !oscPinTwoIsCrystal && !externalOscEnable;
	endproperty
	a_pinsIo: assert property (p_pinsIo) else $error("pins not io");
	property p_lockOne;
		watchdogDisable |=> watchdogDisable;
	endproperty
	a_lockOne: assert property (p_lockOne) else $error("reg one moved");
	property p_lockTwo;
		timebasePrescale == 8'h80 |=> timebasePrescale == 8'h80;
	endproperty
	a_lockTwo: assert property (p_lockTwo) else $error("reg two moved");
	property p_rstDef;
		$rose(resetn) |-> !watchdogDisable && timebasePrescale == 8'h01;
	endproperty
	a_rstDef: assert property (p_rstDef) else $error("bad defaults");
endmodule : wor_option_bank_checker

bind wor_option_bank wor_option_bank_checker u_chk (.*);

/* wor_pkg.sv */
// constants for the write-once option register bank
// What this block does
// - each option register takes only its first write after reset
// - reset forces every option bit to zero, except power-on-only bits
// - the two registers sit at consecutive addresses 0x1E and 0x1F
// - reads are allowed any time and return current settings
// - voltage monitor mode bit is cleared only by power-on reset
// - stop recovery delay is 32 or 4096 oscillator cycles
// - watchdog timeout is 262128 or 8176 oscillator cycles
// - serial port clock is bus clock when bit is 1, else oscillator
// - external clock enable clear keeps both oscillator pins as I/O
// - external clock enable makes pin one a clock, pin two crystal if set
// - crystal enable selects crystal range monitor, else 60 Hz to 32 MHz
// - stabilization divider times out at 4096 with crystal, else 16
// - slow crystal bit selects slow crystal and sub-307.2 kHz monitor range
// - timebase select bit inserts an extra divide-by-128 prescaler
// - oscillator-on-in-stop keeps clocks running in stop, else held low
// - short recovery bit 1 gives 32 cycle stop exit, else 4096
// - watchdog rate bit 1 gives 8176 cycle timeout, else 262128
// - stop enable bit 0 makes stop an illegal opcode
package wor_pkg;
	localparam logic [31:0] OPT_ONE_ADDR = 32'h0000001F;
	localparam logic [31:0] OPT_TWO_ADDR = 32'h0000001E;
	localparam logic [31:0] OPT_ONE_BYTE = 32'h0000007C;
	localparam logic [31:0] OPT_TWO_BYTE = 32'h00000078;
	localparam logic [7:0] OPT_ONE_RESET = 8'h00;
	localparam logic [7:0] OPT_TWO_RESET = 8'h00;
	// option register one fields
	localparam int WDOG_DIS_BIT = 0;
	localparam int STOP_EN_BIT = 1;
	localparam int SHORT_REC_BIT = 2;
	localparam int VMON_MODE_BIT = 3;
	localparam int WDOG_RATE_BIT = 7;
	// option register two fields
	localparam int OSC_STOP_BIT = 0;
	localparam int TB_PRE_BIT = 1;
	localparam int EXT_CLK_BIT = 3;
	localparam int SLOW_XTAL_BIT = 4;
	localparam int XTAL_EN_BIT = 5;
	localparam int SER_SRC_BIT = 6;
	// cycle counts, timebase prescale values and AXI response codes
	localparam logic [12:0] STOP_REC_SHORT = 13'h0020;
	localparam logic [12:0] STOP_REC_LONG = 13'h1000;
	localparam logic [17:0] WDOG_SHORT = 18'h01FF0;
	localparam logic [17:0] WDOG_LONG = 18'h3FFF0;
	localparam logic [12:0] STAB_XTAL = 13'h1000;
	localparam logic [12:0] STAB_EXT = 13'h0010;
	localparam logic [7:0] TB_PRESCALE = 8'h80;
	localparam logic [7:0] TB_BYPASS = 8'h01;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : wor_pkg
